// ===== fetch_pipeline_memory_map_test.sv
// Bench: random load, add and store runs, then a sweep of the whole map.
// Assumes the memory model and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module fetch_pipeline_memory_map_test;
    logic clk_sys = 0, rst = 1, ext_m = 0, int_m = 0;
    wire [10:0] pa;
    wire [11:0] pd, ir;
    wire [6:0] ra, wa;
    wire [7:0] rd, wd, wk;
    wire we, cko, cke, p1, p2, p3, p4, iv;
    wire [2:0] fr;
    integer err_total = 0, checks_done = 0, seed = 32'h554b, cyc = 0;
    integer k = 0, n = 24;
    logic [11:0] prog [0:23];
    logic [11:0] ops [0:2] = '{12'h110, 12'h310, 12'h211};
    logic [7:0] v, w;
    fpm_core i_fpm_core (.clk_sys(clk_sys), .rst(rst),
        .external_rc_osc_mode(ext_m), .internal_rc_osc_mode(int_m),
        .prog_addr(pa), .prog_data(pd), .data_raddr_ff(ra),
        .data_rdata(rd), .data_waddr_ff(wa), .data_wdata_ff(wd),
        .data_we_ff(we), .clock_output_pin(cko), .clock_output_en_n(cke),
        .phase_one(p1), .phase_two(p2), .phase_three(p3), .phase_four(p4),
        .instr_ff(ir), .instr_valid_ff(iv), .fetch_region(fr),
        .work_ff(wk));
    fpm_mem_model i_fpm_mem_model (.clk_sys(clk_sys), .prog_addr(pa),
        .prog_data(pd), .data_raddr(ra), .data_rdata(rd),
        .data_waddr(wa), .data_wdata(wd), .data_we(we));
    task check(input [11:0] s, e, input string t);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s exp %h seen %h", t, e, s);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    function [2:0] region(input [10:0] a);
        region = a < 11'h400 ? 3'h0 : a < 11'h440 ? 3'h1 :
            a < 11'h444 ? 3'h2 : a < 11'h448 ? 3'h3 :
            a < 11'h4a0 ? 3'h4 : a < 11'h7ff ? 3'h5 : 3'h6;
    endfunction
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // Words past the random block are zero, so they change nothing.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 40000) begin
            err_total++;
            close_out;
        end
        if (!rst) begin
            check(12'(fr), 12'(region(pa)), "region");
            check(12'(cko), 12'((ext_m | int_m) & (p3 | p4)), "clock_output_pin");
            if (p2 && iv) begin
                if (k == 0) i_fpm_mem_model.prog[11'h3ff] = 12'h000;
                check(ir, k < n ? prog[k] : 12'h000, "instr");
                if (k > 1) check(12'(wk), 12'(w), "work");
                if (k < n && prog[k][11:8] == 4'h1) w = v;
                if (k < n && prog[k][11:8] == 4'h3) w = w + v;
                k++;
            end
            if (we) check(12'(wd), 12'(w), "store");
            if (we) check(12'(wa), 12'h051, "store addr");
        end
    end
    initial begin
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys);
            rst <= 1;
            {ext_m, int_m} <= 2'(m);
            v = 8'($random(seed));
            prog[0] = 12'ha00;
            prog[1] = 12'h110;
            for (int i = 2; i < n; i++) begin
                prog[i] = ops[$unsigned($random(seed)) % 3];
            end
            for (int i = 0; i < 2048; i++) begin
                i_fpm_mem_model.prog[i] = i < n - 1 ? prog[i + 1] : 0;
            end
            i_fpm_mem_model.prog[11'h3ff] = prog[0];
            for (int i = 0; i < 128; i++) begin
                i_fpm_mem_model.regs[i] = v;
            end
            repeat (8) @(posedge clk_sys);
            k = 0;
            rst <= 0;
            @(posedge clk_sys);
            check(12'(cke), 12'(m == 0), "clock drive");
            for (int c = 0; c < 9000 && pa !== 11'h7ff; c++) begin
                @(posedge clk_sys);
            end
            check(12'(pa), 12'h7ff, "sweep end");
            repeat (4) @(posedge clk_sys);
            check(12'(k > 2000), 12'h1, "count");
        end
        close_out;
    end
endmodule
`default_nettype wire

// ===== fpm_core.v
// Fetch and execute sequencing core with program and data memory ports.
// Assumes program memory answers combinationally to prog_addr and the
// register file answers combinationally to data_raddr.
// What this block does
// RULE_01: Divide clock by four into four phases.
// RULE_02: Fetch: increment PC phase_one, latch phase_four.
// RULE_03: Execute: load IR phase_one, run later.
// RULE_04: Read operand phase_two, write phase_four.
// RULE_05: Fetch overlaps execute, one per cycle.
// RULE_06: PC changes take two cycles, flush prefetch.
// RULE_07: RC modes drive clock out at quarter.
// RULE_08: Eleven-bit PC, 2K twelve-bit program words.
// RULE_09: User memory 0x000-0x3FF, reset vector 0x3FF.
// RULE_10: Flash data block at 400h-43Fh.
// RULE_11: Configuration 0x440-0x7FF, word at 0x7FF.
// RULE_12: Addresses 0x448-0x49F reserved.
// RULE_13: User ID words at 0x440-0x443.
// RULE_14: Calibration backups at 0x444-0x447.
// RULE_15: One status bit selects program page.
// RULE_16: Pointer bits select data memory bank.
// RULE_17: Sixteen special, sixty-seven general registers.
// RULE_18: Working register is unaddressable 8-bit accumulator.
// RULE_19: Reset restarts phase_one, empty prefetch.
`timescale 1ns/10ps
`default_nettype none
`include "fpm_defines.vh"
module fpm_core #(
    parameter PC_W = `FPM_PC_W,
    parameter WORD_W = `FPM_WORD_W,
    parameter DATA_W = `FPM_DATA_W
) (
    input wire clk_sys,
    input wire rst,
    input wire external_rc_osc_mode,
    input wire internal_rc_osc_mode,
    output wire [PC_W-1:0] prog_addr,
    input wire [WORD_W-1:0] prog_data,
    output reg [6:0] data_raddr_ff,
    input wire [DATA_W-1:0] data_rdata,
    output reg [6:0] data_waddr_ff,
    output reg [DATA_W-1:0] data_wdata_ff,
    output reg data_we_ff,
    output wire clock_output_pin,
    output wire clock_output_en_n,
    output wire phase_one,
    output wire phase_two,
    output wire phase_three,
    output wire phase_four,
    output reg [WORD_W-1:0] instr_ff,
    output reg instr_valid_ff,
    output wire [2:0] fetch_region,
    output reg [DATA_W-1:0] work_ff
);
    localparam ST_RESET = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_FLUSH = 2'h2;
    // Register file depth that the bank addressing must cover.
    localparam REG_WORDS = `FPM_NUM_SFR + `FPM_NUM_GPR; // RULE_17

    wire [3:0] phase;
    wire clk_out_raw;
    reg [PC_W-1:0] pc_ff;
    reg [WORD_W-1:0] fetch_ff;
    reg fetch_valid_ff;
    reg [1:0] state_ff;
    reg [DATA_W-1:0] operand_ff;
    reg page_ff;
    reg [6:0] fsr_ff;
    reg branch_ff;
    reg [PC_W-1:0] target_ff;
    reg [DATA_W-1:0] alu_res;
    reg [6:0] nxt_raddr;
    reg is_branch;
    reg [PC_W-1:0] br_target;
    reg wr_dest;

    fpm_phase_gen u_phase (
        .clk_sys(clk_sys),
        .rst(rst),
        .phase_ff(phase),
        .clock_output_ff(clk_out_raw)
    );

    fpm_map_decode u_map (
        .addr(pc_ff),
        .region(fetch_region),
        .is_reset_vec(),
        .is_user()
    );

    assign phase_one = phase[0]; // RULE_01
    assign phase_two = phase[1];
    assign phase_three = phase[2];
    assign phase_four = phase[3];

    // Only the RC modes free the oscillator output pin for the clock.
    wire rc_mode = external_rc_osc_mode | internal_rc_osc_mode;
    assign clock_output_pin = rc_mode & clk_out_raw; // RULE_07
    assign clock_output_en_n = ~rc_mode; // RULE_07

    assign prog_addr = pc_ff; // RULE_08

    // Bank address: file address low five bits, plus pointer bank bits only when bit 4 is set.
    function [6:0] bank_addr;
        input [4:0] f;
        input [6:0] ptr;
        begin
            if (f[4] == 1'b0) begin
                bank_addr = {2'h0, f};
            end else begin
                bank_addr = {ptr[`FPM_FSR_BANK_HI:`FPM_FSR_BANK_LO], f};
            end
        end
    endfunction

    // Minimal decode: 12-bit words, top nibble picks the operation.
    // 0x0: no-op, 0x1: move file to working, 0x2: move working to file,
    // 0x3: add file to working, 0xa/0xb: jump within page (9-bit).
    always @* begin
        // Taken from the word about to execute, so the phase_two read
        // already sees this instruction's own operand address.
        nxt_raddr = bank_addr(fetch_ff[4:0], fsr_ff); // RULE_16
        is_branch = instr_valid_ff &&
            (instr_ff[11:9] == 3'h5);
        br_target = {1'b0, page_ff, instr_ff[8:0]}; // RULE_15
        wr_dest = instr_valid_ff && (instr_ff[11:8] == 4'h2);
        alu_res = work_ff;
        if (instr_ff[11:8] == 4'h3) begin
            alu_res = work_ff + operand_ff; // RULE_18
        end else if (instr_ff[11:8] == 4'h1) begin
            alu_res = operand_ff;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            pc_ff <= `FPM_RESET_VEC; // RULE_09
            fetch_ff <= {WORD_W{1'b0}};
            fetch_valid_ff <= 1'b0; // RULE_19
            instr_ff <= {WORD_W{1'b0}};
            instr_valid_ff <= 1'b0;
            state_ff <= ST_RESET;
            operand_ff <= {DATA_W{1'b0}};
            work_ff <= {DATA_W{1'b0}};
            page_ff <= 1'b0;
            fsr_ff <= 7'h40;
            branch_ff <= 1'b0;
            target_ff <= {PC_W{1'b0}};
            data_raddr_ff <= 7'h00;
            data_waddr_ff <= 7'h00;
            data_wdata_ff <= {DATA_W{1'b0}};
            data_we_ff <= 1'b0;
        end else begin
            data_we_ff <= 1'b0;
            if (phase_one) begin
                // Prefetched word becomes the executing instruction.
                instr_ff <= fetch_ff; // RULE_03
                instr_valid_ff <= fetch_valid_ff && (state_ff == ST_RUN);
                data_raddr_ff <= nxt_raddr; // RULE_04
                if (branch_ff) begin
                    pc_ff <= target_ff; // RULE_06
                    branch_ff <= 1'b0;
                end else if (state_ff != ST_RESET) begin
                    // After reset the first fetch is the vector itself.
                    pc_ff <= pc_ff + 1'b1; // RULE_02
                end
            end
            if (phase_two) begin
                operand_ff <= data_rdata; // RULE_04
            end
            if (phase_three && is_branch) begin
                // Discard the word already in flight.
                branch_ff <= 1'b1; // RULE_06
                target_ff <= br_target;
                state_ff <= ST_FLUSH;
            end
            if (phase_four) begin
                fetch_ff <= prog_data; // RULE_02
                fetch_valid_ff <= 1'b1; // RULE_05
                // A flush ends only once the target word is latched.
                if (state_ff == ST_RESET ||
                    (state_ff == ST_FLUSH && !branch_ff)) begin
                    // The word just latched is good for next cycle.
                    state_ff <= ST_RUN; // RULE_19
                end
                if (wr_dest) begin
                    data_waddr_ff <= data_raddr_ff;
                    data_wdata_ff <= work_ff;
                    data_we_ff <= 1'b1; // RULE_04
                    if (data_raddr_ff == `FPM_STATUS_ADDR) begin
                        page_ff <= work_ff[`FPM_PAGE_BIT]; // RULE_15
                    end
                    if (data_raddr_ff == `FPM_FSR_ADDR) begin
                        fsr_ff <= work_ff[6:0]; // RULE_16
                    end
                end else if (instr_valid_ff) begin
                    work_ff <= alu_res; // RULE_18
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== fpm_core_checker.sv
// Timing checks on the ports of the sequencing core.
// Assumes it is bound onto every core instance.
`timescale 1ns/10ps
`default_nettype none
module fpm_core_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic external_rc_osc_mode,
    input wire logic internal_rc_osc_mode,
    input wire logic [10:0] prog_addr,
    input wire logic [11:0] prog_data,
    input wire logic data_we_ff,
    input wire logic clock_output_en_n,
    input wire logic phase_one,
    input wire logic phase_two,
    input wire logic phase_three,
    input wire logic phase_four,
    input wire logic [11:0] instr_ff,
    input wire logic instr_valid_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire rc = external_rc_osc_mode | internal_rc_osc_mode;
    wire go = phase_two && instr_valid_ff;
    wire jmp = go && instr_ff[11:9] == 3'h5;
    phase_order_a:
    assert property (phase_four |=> phase_one ##1 phase_two ##1 phase_three
        ##1 phase_four) else $error("phase order");
    phase_onehot_a:
    assert property ($onehot({phase_one, phase_two, phase_three,
        phase_four})) else $error("phase overlap");
    pc_step_a:
    assert property (go && !$past(rst) |-> prog_addr ==
        $past(prog_addr) + 11'h1) else $error("pc step");
    ir_load_a:
    assert property (go && !$past(rst, 2) |-> instr_ff ==
        $past(prog_data, 2)) else $error("ir load");
    write_slot_a:
    assert property (data_we_ff |-> $past(phase_four) ##1 !data_we_ff)
        else $error("write slot");
    jump_flush_a:
    assert property (jmp |-> ##4 !instr_valid_ff ##4 instr_valid_ff)
        else $error("jump flush");
    clk_drive_a:
    assert property ($stable(rc) |-> clock_output_en_n == !rc)
        else $error("clock drive");
    reset_state_a:
    assert property (disable iff (1'b0) rst |=> phase_one &&
        !instr_valid_ff && prog_addr == 11'h3ff) else $error("reset");
endmodule
bind fpm_core fpm_core_checker i_fpm_core_checker (.clk_sys(clk_sys),
    .rst(rst), .external_rc_osc_mode(external_rc_osc_mode),
    .internal_rc_osc_mode(internal_rc_osc_mode), .prog_addr(prog_addr),
    .prog_data(prog_data), .data_we_ff(data_we_ff),
    .clock_output_en_n(clock_output_en_n), .phase_one(phase_one),
    .phase_two(phase_two), .phase_three(phase_three),
    .phase_four(phase_four), .instr_ff(instr_ff),
    .instr_valid_ff(instr_valid_ff));
`default_nettype wire

// ===== fpm_defines.vh
// Shared constants of the fetch and sequencing core.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef FPM_DEFINES_VH
`define FPM_DEFINES_VH
`define FPM_PHASES 4
`define FPM_PC_W 11
`define FPM_WORD_W 12
`define FPM_DATA_W 8
`define FPM_FADDR_W 7
`define FPM_USER_LO 11'h000
`define FPM_USER_HI 11'h3ff
`define FPM_RESET_VEC 11'h3ff
`define FPM_FDATA_LO 11'h400
`define FPM_FDATA_HI 11'h43f
`define FPM_CFG_LO 11'h440
`define FPM_CFG_HI 11'h7ff
`define FPM_CFG_WORD 11'h7ff
`define FPM_UID_LO 11'h440
`define FPM_UID_HI 11'h443
`define FPM_CAL_LO 11'h444
`define FPM_CAL_HI 11'h447
`define FPM_RSV_LO 11'h448
`define FPM_RSV_HI 11'h49f
`define FPM_PAGE_SIZE 512
`define FPM_NUM_SFR 16
`define FPM_NUM_GPR 67
`define FPM_BANK_SIZE 32
`define FPM_STATUS_ADDR 7'h03
`define FPM_FSR_ADDR 7'h04
`define FPM_PAGE_BIT 5
`define FPM_FSR_BANK_LO 5
`define FPM_FSR_BANK_HI 6
`define FPM_REGION_USER 3'h0
`define FPM_REGION_FDATA 3'h1
`define FPM_REGION_UID 3'h2
`define FPM_REGION_CAL 3'h3
`define FPM_REGION_RSV 3'h4
`define FPM_REGION_CFG 3'h5
`define FPM_REGION_CFGW 3'h6
`endif

// ===== fpm_map_decode.v
// Program address map decoder.
// Assumes an 11-bit program address from the core, purely combinational.
`timescale 1ns/10ps
`default_nettype none
`include "fpm_defines.vh"
module fpm_map_decode (
    input wire [10:0] addr,
    output reg [2:0] region,
    output wire is_reset_vec,
    output wire is_user
);
    assign is_reset_vec = (addr == `FPM_RESET_VEC);
    assign is_user = (addr <= `FPM_USER_HI);
    always @* begin
        if (addr <= `FPM_USER_HI) begin
            region = `FPM_REGION_USER;
        end else if (addr <= `FPM_FDATA_HI) begin
            region = `FPM_REGION_FDATA; // RULE_10
        end else if (addr <= `FPM_UID_HI) begin
            region = `FPM_REGION_UID; // RULE_13
        end else if (addr <= `FPM_CAL_HI) begin
            region = `FPM_REGION_CAL; // RULE_14
        end else if (addr <= `FPM_RSV_HI) begin
            region = `FPM_REGION_RSV; // RULE_12
        end else if (addr == `FPM_CFG_WORD) begin
            region = `FPM_REGION_CFGW; // RULE_11
        end else begin
            region = `FPM_REGION_CFG; // RULE_11
        end
    end
endmodule
`default_nettype wire

// ===== fpm_mem_model.sv
// Program memory and register file that face the sequencing core.
// Assumes the bench fills both arrays while reset is held.
`timescale 1ns/10ps
`default_nettype none
module fpm_mem_model (
    input wire logic clk_sys,
    input wire logic [10:0] prog_addr,
    output logic [11:0] prog_data,
    input wire logic [6:0] data_raddr,
    output logic [7:0] data_rdata,
    input wire logic [6:0] data_waddr,
    input wire logic [7:0] data_wdata,
    input wire logic data_we
);
    logic [11:0] prog [0:2047];
    logic [7:0] regs [0:127];
    // Both arrays answer at once, as the core samples them in one phase.
    assign prog_data = prog[prog_addr];
    assign data_rdata = regs[data_raddr];
    always @(posedge clk_sys) begin
        if (data_we) begin
            regs[data_waddr] <= data_wdata;
        end
    end
endmodule
`default_nettype wire

// ===== fpm_phase_gen.v
// Four-phase generator: one phase per input clock, four per instruction.
// Assumes clk_sys is the oscillator clock and rst is synchronous.
`timescale 1ns/10ps
`default_nettype none
`include "fpm_defines.vh"
module fpm_phase_gen (
    input wire clk_sys,
    input wire rst,
    output reg [3:0] phase_ff,
    output reg clock_output_ff
);
    // One-hot ring keeps the four phases strictly non-overlapping.
    always @(posedge clk_sys) begin
        if (rst) begin
            phase_ff <= 4'h1;
            clock_output_ff <= 1'b0;
        end else begin
            phase_ff <= {phase_ff[2:0], phase_ff[3]};
            // High across phase_three and phase_four: one cycle per four.
            clock_output_ff <= phase_ff[1] | phase_ff[2];
        end
    end
endmodule
`default_nettype wire
